// >>> logic/scr_params.svh
`ifndef SCR_PARAMS_SVH
`define SCR_PARAMS_SVH
// ====================================================================
// command codes
`define SCR_CMD_ENTER     8'h72
`define SCR_ENTER_KEY     8'hD1
`define SCR_CMD_COUNTED   8'h62
`define SCR_CMD_ACQUIRE   8'h50
`define SCR_CMD_TRIM      8'h65
`define SCR_CMD_DAC       8'h60
`define SCR_RAW1_LO       8'hD0
`define SCR_RAW1_HI       8'hD6
`define SCR_RAW2_LO       8'hD8
`define SCR_RAW2_HI       8'hDB
`define SCR_RAM_LO        8'h10
`define SCR_RAM_HI        8'h1E
`define SCR_EEP_LO        8'h30
`define SCR_EEP_HI        8'h43
`define SCR_WRAM_LO       8'h80
`define SCR_WRAM_HI       8'h8E
`define SCR_WEEP_LO       8'hA0
`define SCR_WEEP_HI       8'hB2
// ====================================================================
// answer codes and checksum
`define SCR_SUCCESS_HI    8'hC3
`define SCR_BAD_WORD      16'hCF00
`define SCR_CKS_BASE      8'hFF
`define SCR_ZERO_BYTE     8'h00
// ====================================================================
// timing
`define SCR_CLK_NS        50
`define SCR_GEN_NS        50000
// fixed command overhead is counted in clocks, not in time
`define SCR_OVH_CYC       150
`define SCR_GEN_CYC       (`SCR_GEN_NS / `SCR_CLK_NS)
`endif

// >>> logic/scr_pkg.sv
`default_nettype none
package scr_pkg;
  // ==================================================================
  // command carrier
  typedef struct packed {
    logic        onewire;
    logic [7:0]  code;
    logic [15:0] data;
  } scr_cmd_s;
  // ==================================================================
  // command classes and sequencer states
  typedef enum logic [3:0] {
    SCR_CL_RAW1  = 4'b0000,
    SCR_CL_RAW2  = 4'b0001,
    SCR_CL_READ  = 4'b0010,
    SCR_CL_CNT   = 4'b0011,
    SCR_CL_ACQ   = 4'b0100,
    SCR_CL_TRIM  = 4'b0101,
    SCR_CL_DAC   = 4'b0110,
    SCR_CL_ENTER = 4'b0111,
    SCR_CL_OK    = 4'b1000,
    SCR_CL_BAD   = 4'b1001
  } scr_class_e;
  typedef enum logic [1:0] {
    SCR_ST_IDLE = 2'b00,
    SCR_ST_RUN  = 2'b01
  } scr_state_e;
endpackage : scr_pkg
`default_nettype wire

// >>> logic/scr_result_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "scr_params.svh"
// Behaviour
// - raw conversion commands answer raw value, checksum, echo; no dac
// - single raw commands D0-D6 take overhead plus one conversion
// - combined raw commands D8-DB take twice the single time
// - clock halving doubles only the conversion part
// - decode single raw opcodes D0 to D6
// - decode combined raw opcodes D8 to DB
// - oscillator acquire and trim only accepted over one-wire
// - in session a valid command starts its processing
// - read commands put requested data into the result words
// - commands arriving while busy are ignored
// - no address acknowledge without a detected start condition
// - two 16-bit result words, refreshed by mode and command
// - one-wire limit setting restricts one-wire access in free-run
// - free-run: conditioned value, then checksum and zero byte
// - memory reads: data, then checksum and echoed command
// - counted conversion: raw bridge then raw temperature, no echo
// - trim echoes 65, analog-set echoes 60, acquire echoes 50
// - fault mode: error code with top bit set, checksum, zero
// - checksum is FF minus high byte minus low byte
// - words update whole so checksum follows the new value
// - opcode 72 with D1 enters the command session
// - every session command answers data or a success/fail code
module scr_result_port
  import scr_pkg::*;
#(
  parameter int unsigned ADC_CONV_CYC = 600,
  parameter int unsigned CNT_W        = 20
)(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        link_clk,
  input  wire logic        link_cmd_valid,
  input  wire scr_cmd_s    link_cmd,
  input  wire logic        link_addr_byte,
  input  wire logic        link_start_seen,
  output logic             link_addr_ack,
  output logic             link_cmd_pending,
  input  wire logic        adc_clock_halve,
  input  wire logic        onewire_limit_select,
  input  wire logic [15:0] osc_reference_config,
  input  wire logic [15:0] osc_ratio_count,
  input  wire logic [15:0] cond_value,
  input  wire logic [15:0] raw_value,
  input  wire logic [15:0] raw_bridge,
  input  wire logic [15:0] raw_temp,
  input  wire logic [15:0] mem_rdata,
  input  wire logic        fault_active,
  input  wire logic [14:0] fault_code,
  output logic [15:0]      result_word_first,
  output logic [15:0]      result_word_second,
  output logic             command_session_mode,
  output logic             cmd_busy,
  output scr_cmd_s         cmd_current,
  output logic             dac_load,
  output logic             osc_trim_write
);

  // ==================================================================
  // elaboration check
  localparam int unsigned MAX_LEN = 4 * (`SCR_OVH_CYC + 2 * ADC_CONV_CYC);
  if (ADC_CONV_CYC == 0 || CNT_W > 31 || MAX_LEN >= (1 << CNT_W))
  begin : g_bad_size
    $error("scr_result_port: counter too narrow for processing times");
  end

  // ==================================================================
  // helpers
  function automatic logic [7:0] cks(input logic [15:0] w);
    cks = `SCR_CKS_BASE - w[15:8] - w[7:0];
  endfunction : cks

  function automatic logic [31:0] answer(input logic [15:0] w,
                                         input logic [7:0]  echo);
    answer = {w, cks(w), echo};
  endfunction : answer

  function automatic logic in_rng(input logic [7:0] c,
                                  input logic [7:0] lo,
                                  input logic [7:0] hi);
    in_rng = (c >= lo) && (c <= hi);
  endfunction : in_rng

  function automatic scr_class_e classify(input scr_cmd_s c);
    classify = SCR_CL_BAD;
    if (in_rng(c.code, `SCR_RAW1_LO, `SCR_RAW1_HI))
      classify = SCR_CL_RAW1;
    else if (in_rng(c.code, `SCR_RAW2_LO, `SCR_RAW2_HI))
      classify = SCR_CL_RAW2;
    else if (in_rng(c.code, `SCR_RAM_LO, `SCR_RAM_HI) ||
             in_rng(c.code, `SCR_EEP_LO, `SCR_EEP_HI))
      classify = SCR_CL_READ;
    else if (c.code == `SCR_CMD_COUNTED)
      classify = SCR_CL_CNT;
    else if (c.code == `SCR_CMD_ACQUIRE && c.onewire)
      classify = SCR_CL_ACQ;
    else if (c.code == `SCR_CMD_TRIM && c.onewire)
      classify = SCR_CL_TRIM;
    else if (c.code == `SCR_CMD_DAC)
      classify = SCR_CL_DAC;
    else if (c.code == `SCR_CMD_ENTER && c.data[15:8] == `SCR_ENTER_KEY)
      classify = SCR_CL_ENTER;
    else if (in_rng(c.code, `SCR_WRAM_LO, `SCR_WRAM_HI) ||
             in_rng(c.code, `SCR_WEEP_LO, `SCR_WEEP_HI) ||
             c.code == 8'h6C || c.code == 8'hC0 || c.code == 8'hC3 ||
             c.code == 8'hC8 || c.code == 8'hC9 || c.code == 8'hCA ||
             c.code == 8'hCF)
      classify = SCR_CL_OK;
  endfunction : classify

  // ==================================================================
  // link domain: command capture and address acknowledge
  logic     req_tgl;
  logic     ack_s1;
  logic     ack_s2;
  logic     ack_tgl;
  scr_cmd_s link_hold;
  wire      link_busy = req_tgl ^ ack_s2;

  // the held command stays frozen until the core's acknowledge toggle returns, taken or not
  always_ff @(posedge link_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      req_tgl          <= 1'b0;
      ack_s1           <= 1'b0;
      ack_s2           <= 1'b0;
      link_hold        <= '0;
      link_addr_ack    <= 1'b0;
      link_cmd_pending <= 1'b0;
    end
    else
    begin
      ack_s1           <= ack_tgl;
      ack_s2           <= ack_s1;
      link_addr_ack    <= link_addr_byte & link_start_seen;
      link_cmd_pending <= link_busy | link_cmd_valid;
      if (link_cmd_valid && !link_busy)
      begin
        link_hold <= link_cmd;
        req_tgl   <= ~req_tgl;
      end
    end
  end

  // ==================================================================
  // core domain: crossing and acceptance
  logic       req_s1;
  logic       req_s2;
  scr_state_e state;
  scr_class_e cls_cur;
  logic [CNT_W-1:0] cnt;
  logic [15:0]      passes;
  logic             halve_l;

  wire        evt       = req_s2 ^ ack_tgl;
  wire scr_class_e evt_cls = classify(link_hold);
  wire        ow_block  = !command_session_mode & onewire_limit_select &
                          link_hold.onewire;
  wire        take      = evt && state == SCR_ST_IDLE && !ow_block &&
                          (command_session_mode ||
                           evt_cls == SCR_CL_ENTER);
  wire        take_bad  = take && evt_cls == SCR_CL_BAD;
  wire        start     = take && evt_cls != SCR_CL_BAD;
  wire        done      = state == SCR_ST_RUN && cnt == 1;
  wire        more      = cls_cur == SCR_CL_CNT && passes > 16'h0001;

  // ==================================================================
  // processing time
  wire [CNT_W-1:0] conv_cyc = adc_clock_halve ?
                              CNT_W'(2 * ADC_CONV_CYC) :
                              CNT_W'(ADC_CONV_CYC);
  wire [CNT_W-1:0] single   = CNT_W'(`SCR_OVH_CYC) + conv_cyc;
  wire [CNT_W-1:0] combined = single << 1;
  wire [CNT_W-1:0] evt_len  =
    (evt_cls == SCR_CL_RAW1) ? single :
    (evt_cls == SCR_CL_RAW2) ? combined :
    (evt_cls == SCR_CL_CNT)  ? combined << 1 :
                               CNT_W'(`SCR_GEN_CYC);

  logic [CNT_W-1:0] next_cnt;
  scr_state_e       next_state;
  always_comb
  begin
    next_cnt   = cnt;
    next_state = state;
    case (state)
      SCR_ST_IDLE:
      begin
        if (start)
        begin
          next_cnt   = evt_len;
          next_state = SCR_ST_RUN;
        end
      end
      SCR_ST_RUN:
      begin
        if (done && more)
          next_cnt = combined << 1;
        else if (done)
          next_state = SCR_ST_IDLE;
        else
          next_cnt = cnt - 1'b1;
      end
      default:
        next_state = SCR_ST_IDLE;
    endcase
  end

  // ==================================================================
  // result words
  logic [31:0] next_words;
  wire  [15:0] fault_word = {1'b1, fault_code};
  wire  [7:0]  echo       = cmd_current.code;
  always_comb
  begin
    next_words = {result_word_first, result_word_second};
    if (!command_session_mode && fault_active)
      next_words = answer(fault_word, `SCR_ZERO_BYTE);
    else if (!command_session_mode)
      next_words = answer(cond_value, `SCR_ZERO_BYTE);
    else if (take_bad)
      next_words = answer(`SCR_BAD_WORD, link_hold.code);
    else if (done)
    begin
      case (cls_cur)
        SCR_CL_RAW1, SCR_CL_RAW2:
          next_words = answer(raw_value, echo);
        SCR_CL_READ:
          next_words = answer(mem_rdata, echo);
        SCR_CL_CNT:
          next_words = {raw_bridge, raw_temp};
        SCR_CL_ACQ:
          next_words = answer(osc_ratio_count, echo);
        SCR_CL_TRIM:
          next_words = answer(osc_reference_config, echo);
        SCR_CL_DAC:
          next_words = answer(cmd_current.data, echo);
        default:
          next_words = answer({`SCR_SUCCESS_HI, echo}, echo);
      endcase
    end
  end

  // ==================================================================
  // core registers
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      req_s1               <= 1'b0;
      req_s2               <= 1'b0;
      ack_tgl              <= 1'b0;
      state                <= SCR_ST_IDLE;
      cls_cur              <= SCR_CL_BAD;
      cnt                  <= '0;
      passes               <= 16'h0000;
      halve_l              <= 1'b0;
      cmd_current          <= '0;
      cmd_busy             <= 1'b0;
      command_session_mode <= 1'b0;
      result_word_first    <= 16'h0000;
      result_word_second   <= 16'h0000;
      dac_load             <= 1'b0;
      osc_trim_write       <= 1'b0;
    end
    else
    begin
      req_s1   <= req_tgl;
      req_s2   <= req_s1;
      ack_tgl  <= req_s2; // any command seen is released to the link
      state    <= next_state;
      cnt      <= next_cnt;
      cmd_busy <= next_state == SCR_ST_RUN;
      {result_word_first, result_word_second} <= next_words;
      dac_load       <= start && evt_cls == SCR_CL_DAC;
      osc_trim_write <= start && evt_cls == SCR_CL_TRIM;
      if (start)
      begin
        cmd_current <= link_hold;
        cls_cur     <= evt_cls;
        halve_l     <= adc_clock_halve;
        passes      <= link_hold.data;
      end
      else if (done && more)
        passes <= passes - 16'h0001;
      if (take && evt_cls == SCR_CL_ENTER)
        command_session_mode <= 1'b1;
    end
  end

  // ==================================================================
  // checks
  localparam int OVH = `SCR_OVH_CYC;
  localparam int ADC = ADC_CONV_CYC;
  logic [CNT_W-1:0] run_age;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      run_age <= '0;
    else if (start)
      run_age <= CNT_W'(1);
    else if (state == SCR_ST_RUN && !(done && more))
      run_age <= run_age + 1'b1;
    else if (done && more)
      run_age <= CNT_W'(1);
  end

  property p_single_time;
    @(posedge ref_clk) disable iff (!rst_b)
    done && cls_cur == SCR_CL_RAW1 |->
      int'(run_age) == OVH + (halve_l ? 2 * ADC : ADC);
  endproperty
  a_single_time: assert property (p_single_time)
    else $error("single raw command time wrong");

  property p_combined_time;
    @(posedge ref_clk) disable iff (!rst_b)
    done && cls_cur == SCR_CL_RAW2 |->
      int'(run_age) == 2 * (OVH + (halve_l ? 2 * ADC : ADC));
  endproperty
  a_combined_time: assert property (p_combined_time)
    else $error("combined raw command time wrong");

  property p_busy_ignore;
    @(posedge ref_clk) disable iff (!rst_b)
    evt && cmd_busy |=> $stable(cmd_current);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore)
    else $error("command taken while busy");

  property p_raw_answer;
    @(posedge ref_clk) disable iff (!rst_b)
    done && (cls_cur == SCR_CL_RAW1 || cls_cur == SCR_CL_RAW2) |=>
      result_word_second[7:0] == cmd_current.code && !dac_load
      && result_word_first == $past(raw_value);
  endproperty
  a_raw_answer: assert property (p_raw_answer)
    else $error("raw answer malformed");

  // sampled rst_b skips the release edge, where the words are still zero
  property p_checksum;
    @(posedge ref_clk) disable iff (!rst_b)
    rst_b && !command_session_mode |=>
      result_word_second[15:8] == 8'(8'hFF - result_word_first[15:8]
                                     - result_word_first[7:0]);
  endproperty
  a_checksum: assert property (p_checksum)
    else $error("checksum wrong");

  property p_free_run;
    @(posedge ref_clk) disable iff (!rst_b)
    rst_b && !command_session_mode && !fault_active |=>
      result_word_second[7:0] == 8'h00 &&
      result_word_first == $past(cond_value);
  endproperty
  a_free_run: assert property (p_free_run)
    else $error("free-run words wrong");

  property p_fault_flag;
    @(posedge ref_clk) disable iff (!rst_b)
    rst_b && !command_session_mode && fault_active |=>
      result_word_first[15] && result_word_second[7:0] == 8'h00;
  endproperty
  a_fault_flag: assert property (p_fault_flag)
    else $error("fault word lacks flag");

  property p_enter;
    @(posedge ref_clk) disable iff (!rst_b)
    take && evt_cls == SCR_CL_ENTER |=> command_session_mode && cmd_busy;
  endproperty
  a_enter: assert property (p_enter)
    else $error("session not entered");

  property p_i2c_trim;
    @(posedge ref_clk) disable iff (!rst_b)
    take && !link_hold.onewire && link_hold.code == 8'h65 |=>
      !cmd_busy && result_word_first == 16'hCF00;
  endproperty
  a_i2c_trim: assert property (p_i2c_trim)
    else $error("trim accepted over i2c");

  property p_addr_ack;
    @(posedge link_clk) disable iff (!rst_b)
    !link_start_seen |=> !link_addr_ack;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("address acked without start");

endmodule : scr_result_port
`default_nettype wire

// >>> verif/scr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====================================================================
// host calibration controller seen from the link side
module scr_host_model
  import scr_pkg::*;
(
  input  wire logic link_clk,
  input  wire logic link_cmd_pending,
  input  wire logic link_addr_ack,
  output logic      link_cmd_valid,
  output scr_cmd_s  link_cmd,
  output logic      link_addr_byte,
  output logic      link_start_seen
);
  initial
  begin
    link_cmd_valid  = 1'b0;
    link_cmd        = '0;
    link_addr_byte  = 1'b0;
    link_start_seen = 1'b0;
  end
  // ==================================================================
  // one command; gap lets the host be slow, pending is read settled
  task automatic send(input logic        ow,
                      input logic [7:0]  code,
                      input logic [15:0] data,
                      input int unsigned gap);
    repeat (gap + 1) @(posedge link_clk);
    #1;
    while (link_cmd_pending !== 1'b0)
    begin
      @(posedge link_clk);
      #1;
    end
    @(posedge link_clk);
    link_cmd_valid <= 1'b1;
    link_cmd       <= {ow, code, data};
    @(posedge link_clk);
    link_cmd_valid <= 1'b0;
    // released bus shows no stale command
    link_cmd       <= ~{ow, code, data};
  endtask : send
  // ==================================================================
  // address byte with or without a start condition
  task automatic address(input logic start, output logic ack);
    @(posedge link_clk);
    link_start_seen <= start;
    link_addr_byte  <= 1'b1;
    @(posedge link_clk);
    link_addr_byte  <= 1'b0;
    #1 ack = link_addr_ack;
    @(posedge link_clk);
    link_start_seen <= 1'b0;
  endtask : address
endmodule : scr_host_model
`default_nettype wire

// >>> verif/scr_result_port_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "scr_params.svh"
module scr_result_port_test
  import scr_pkg::*;
;
  localparam int unsigned ADC = 4;
  localparam int unsigned OVH = `SCR_OVH_CYC;
  localparam int unsigned GEN = `SCR_GEN_CYC;
  localparam int unsigned SGL = OVH + ADC;
  // long ceiling: whole run is about 11k core cycles
  localparam int          LIMIT = 30000;
  // ==================================================================
  // signals
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_b = 1'b0;
  logic adc_clock_halve = 1'b0;
  logic onewire_limit_select = 1'b0;
  logic fault_active = 1'b0;
  logic [14:0] fault_code = 15'h0000;
  logic [15:0] osc_reference_config = 16'h0312;
  logic [15:0] osc_ratio_count = 16'h0200;
  logic [15:0] cond_value = 16'h1234;
  logic [15:0] raw_value = 16'h7E81;
  logic [15:0] raw_bridge = 16'h1111;
  logic [15:0] raw_temp = 16'h2222;
  logic [15:0] mem_rdata = 16'hA55A;
  wire logic link_cmd_valid, link_addr_byte, link_start_seen;
  wire logic link_addr_ack, link_cmd_pending, command_session_mode;
  wire logic cmd_busy, dac_load, osc_trim_write;
  wire scr_cmd_s link_cmd, cmd_current;
  wire logic [15:0] result_word_first, result_word_second;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;
  int busy_starts = 0;
  int dac_pulses = 0;
  int trim_pulses = 0;
  logic busy_q = 1'b0;
  always #25 ref_clk = ~ref_clk;
  always #15 link_clk = ~link_clk;
  scr_result_port #(.ADC_CONV_CYC(ADC)) dut (.ref_clk, .rst_b, .link_clk,
    .link_cmd_valid, .link_cmd, .link_addr_byte, .link_start_seen,
    .link_addr_ack, .link_cmd_pending, .adc_clock_halve,
    .onewire_limit_select, .osc_reference_config, .osc_ratio_count,
    .cond_value, .raw_value, .raw_bridge, .raw_temp, .mem_rdata,
    .fault_active, .fault_code, .result_word_first, .result_word_second,
    .command_session_mode, .cmd_busy, .cmd_current, .dac_load,
    .osc_trim_write);
  scr_host_model host (.link_clk, .link_cmd_pending, .link_addr_ack,
    .link_cmd_valid, .link_cmd, .link_addr_byte, .link_start_seen);
  // ==================================================================
  // helpers
  function automatic logic [7:0] cks(input logic [15:0] w);
    return 8'hFF - w[15:8] - w[7:0];
  endfunction : cks
  task automatic complete_run;
    if (n_mismatch == 0 && checks > 0)
    begin
      $display("STATUS OK");
    end
    else
    begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  // pulses counted from previous-cycle values, so no edge race
  always @(posedge ref_clk)
  begin
    busy_q <= cmd_busy;
    if (cmd_busy === 1'b1 && busy_q !== 1'b1)
      busy_starts++;
    if (dac_load === 1'b1)
      dac_pulses++;
    if (osc_trim_write === 1'b1)
      trim_pulses++;
    cycles++;
    if (cycles == LIMIT)
    begin
      n_mismatch++;
      complete_run();
    end
  end
  // ==================================================================
  // command that must run: length of busy, answer words, echo
  task automatic run_cmd(input logic ow, input logic [7:0] code,
    input logic [15:0] data, input int unsigned dur,
    input logic [15:0] w1, input logic intrude);
    int unsigned n;
    logic [15:0] w2;
    w2 = (code == 8'h62) ? raw_temp : {cks(w1), code};
    n = 0;
    host.send(ow, code, data, 0);
    while (cmd_busy !== 1'b1 && n < 40)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
    n = 0;
    if (intrude)
      fork
        host.send(1'b0, 8'h10, 16'h0000, 2);
      join_none
    while (cmd_busy === 1'b1 && n < 20000)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
    check(n, dur);
    check(result_word_first, w1);
    check(result_word_second, w2);
    check(32'(cmd_current.code), 32'(code));
  endtask : run_cmd
  // command that must not start a run; first word must then equal w1
  task automatic refuse(input logic ow, input logic [7:0] code,
    input logic [15:0] data, input logic [15:0] w1);
    int s;
    s = busy_starts;
    host.send(ow, code, data, 3);
    repeat (60) @(posedge ref_clk);
    #1;
    check(32'(busy_starts - s), 0);
    check(result_word_first, w1);
  endtask : refuse
  // host reads first and second word, then first word again one core cycle later
  task automatic read_six(input logic [15:0] w1);
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
    @(posedge ref_clk);
    #1 a = result_word_first;
    b = result_word_second;
    @(posedge ref_clk);
    #1 c = result_word_first;
    check({a, c}, {w1, w1});
    check(b, {cks(w1), 8'h00});
  endtask : read_six
  // ==================================================================
  // main sequence
  initial
  begin
    logic ack;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    check({result_word_first, result_word_second}, 32'h1234B900);
    @(posedge ref_clk);
    cond_value <= 16'hFFFF;
    repeat (3) @(posedge ref_clk);
    #1;
    check(result_word_second, 16'h0100);
    @(posedge ref_clk);
    fault_active <= 1'b1;
    fault_code   <= 15'h0012;
    repeat (3) @(posedge ref_clk);
    #1;
    check({result_word_first, result_word_second}, 32'h80126D00);
    @(posedge ref_clk);
    fault_active <= 1'b0;
    cond_value   <= 16'h1234;
    host.address(1'b1, ack);
    check(32'(ack), 1);
    host.address(1'b0, ack);
    check(32'(ack), 0);
    read_six(16'h1234);
    refuse(1'b0, 8'hD0, 16'h0000, 16'h1234);
    @(posedge ref_clk);
    onewire_limit_select <= 1'b1;
    refuse(1'b1, 8'h72, 16'hD100, 16'h1234);
    run_cmd(1'b0, 8'h72, 16'hD100, GEN, 16'hC372, 1'b0);
    check(32'(command_session_mode), 1);
    for (int i = 0; i < 11; i++)
      run_cmd(i[0], (i < 7) ? 8'hD0 + 8'(i) : 8'hD1 + 8'(i),
              16'h0000, (i < 7) ? SGL : 2 * SGL, raw_value, 1'b0);
    @(posedge ref_clk);
    adc_clock_halve <= 1'b1;
    run_cmd(1'b1, 8'hD3, 16'h0000, OVH + 2 * ADC, raw_value, 1'b0);
    run_cmd(1'b0, 8'hD9, 16'h0000, 2 * (OVH + 2 * ADC), raw_value,
            1'b1);
    @(posedge ref_clk);
    adc_clock_halve <= 1'b0;
    check(32'(dac_pulses), 0);
    run_cmd(1'b0, 8'h10, 16'h0000, GEN, mem_rdata, 1'b0);
    run_cmd(1'b1, 8'h43, 16'h0000, GEN, mem_rdata, 1'b0);
    run_cmd(1'b0, 8'h60, 16'h0123, GEN, 16'h0123, 1'b0);
    check(32'(dac_pulses), 1);
    run_cmd(1'b1, 8'h50, 16'h0000, GEN, osc_ratio_count, 1'b0);
    run_cmd(1'b1, 8'h65, 16'h0007, GEN, osc_reference_config,
            1'b0);
    check(32'(trim_pulses), 1);
    refuse(1'b0, 8'h65, 16'h0007, 16'hCF00);
    run_cmd(1'b0, 8'hC0, 16'h0000, GEN, 16'hC3C0, 1'b0);
    run_cmd(1'b0, 8'h62, 16'h0002, 8 * SGL, raw_bridge, 1'b0);
    @(posedge ref_clk);
    cond_value <= 16'h5555;
    repeat (20) @(posedge ref_clk);
    #1;
    check({result_word_first, result_word_second},
          {raw_bridge, raw_temp});
    complete_run();
  end
endmodule : scr_result_port_test
`default_nettype wire
